// ==== tpwm_channel.v ====
/*
 * Triggered PWM channel with AXI4-Lite register slave, optional
 * counting-clock divider, selectable trigger delay and shadowed
 * compare values.
 * Assumes: single clock, trigger from the preceding channel is a
 * one-cycle pulse synchronous to CORE_CLK_IN, one bus master.
 */
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defines.vh"

// Functional notes
// - trigger select restarts period on preceding trigger
// - trigger register delay never loses an edge
// - inverse-level edge also for small second compare
// - every divider setting, including one, works
// - second zero, first above max: 0% duty
// - first zero, second above max: 100% duty
// - second zero, first positive: left aligned
// - leaving 100% emits the inverse-level edge
// - swapped compares with inverted level match
// - direct compare writes act within period
// - shadow values move to compares synchronously
// - compare equal to max differs from above
module tpwm_channel (
    // clock, reset, enable
    input wire CORE_CLK_IN,
    input wire RST_IN,
    input wire CLK_EN_IN,
    // write address channel
    input wire [7:0] S_AXI_AWADDR_IN,
    input wire S_AXI_AWVALID_IN,
    output wire S_AXI_AWREADY_OUT,
    // write data channel
    input wire [31:0] S_AXI_WDATA_IN,
    input wire [3:0] S_AXI_WSTRB_IN,
    input wire S_AXI_WVALID_IN,
    output wire S_AXI_WREADY_OUT,
    // write response channel
    output reg [1:0] S_AXI_BRESP_OUT,
    output reg S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN,
    // read address channel
    input wire [7:0] S_AXI_ARADDR_IN,
    input wire S_AXI_ARVALID_IN,
    output wire S_AXI_ARREADY_OUT,
    // read data channel
    output reg [31:0] S_AXI_RDATA_OUT,
    output reg [1:0] S_AXI_RRESP_OUT,
    output reg S_AXI_RVALID_OUT,
    input wire S_AXI_RREADY_IN,
    // trigger chain
    input wire TRIG_IN,
    output reg TRIG_OUT,
    // waveform
    output reg PWM_OUT
);
    // software state
    reg [`TPWM_CTRL_W-1:0] ctrl_r;
    reg [`TPWM_CMP_W-1:0] compare_first_r;
    reg [`TPWM_CMP_W-1:0] compare_second_r;
    reg [`TPWM_CMP_W-1:0] shadow_first_r;
    reg [`TPWM_CMP_W-1:0] shadow_second_r;
    // channel state
    reg [`TPWM_CNT_W-1:0] cnt_r;
    reg [`TPWM_CNT_W-1:0] cnt_nxt;
    reg [`TPWM_CMP_W-1:0] compare_first_nxt;
    reg [`TPWM_CMP_W-1:0] compare_second_nxt;
    reg level_nxt;
    // decoded controls
    wire chan_en;
    wire trigger_reset_select;
    wire signal_level_bit;
    wire sync_update_en;
    wire [2:0] div_sel;
    wire [1:0] trig_stages;
    // timing
    wire tick;
    wire trig_dly;
    wire own_wrap;
    wire restart;
    wire [`TPWM_CMP_W-1:0] cnt_ext;
    // bus
    wire wr_go;
    wire rd_go;
    wire [7:0] wa;
    wire [31:0] wd_ctrl;
    wire [31:0] wd_cmpf;
    wire [31:0] wd_cmps;
    wire [31:0] wd_shdf;
    wire [31:0] wd_shds;
    wire wr_ctrl;
    wire wr_cmpf;
    wire wr_cmps;
    wire wr_shdf;
    wire wr_shds;
    wire wr_mapped;
    reg [31:0] rd_data;
    reg rd_mapped;

    // byte-lane merge of a write into an old word
    // narrow registers drop the upper bits of a merged word on write
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer k;
        begin
            merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // control fields
    assign chan_en = ctrl_r[`TPWM_CTRL_EN];
    assign trigger_reset_select = ctrl_r[`TPWM_CTRL_TRS];
    assign signal_level_bit = ctrl_r[`TPWM_CTRL_SL];
    assign sync_update_en = ctrl_r[`TPWM_CTRL_SYNC];
    assign div_sel = ctrl_r[`TPWM_CTRL_DIV_HI:`TPWM_CTRL_DIV_LO];
    assign trig_stages = ctrl_r[`TPWM_CTRL_STG_HI:`TPWM_CTRL_STG_LO];

    // counting clock, realigned on every restart
    // so count zero of a triggered period always lasts 2^sel cycles
    tpwm_clkdiv u_div (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CLK_EN_IN),
        .sel_in(div_sel),
        .restart_in(restart),
        .tick_out(tick)
    );

    // delayed trigger from the preceding channel
    // zero stages passes the pulse on in the cycle it arrives
    tpwm_trigpipe u_trig (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CLK_EN_IN),
        .stages_in(trig_stages),
        .trig_in(TRIG_IN),
        .trig_out(trig_dly)
    );

    // write handshake: both channels taken together, one write at a time.
    // waiting for the pair keeps the slave free of address or data
    // buffers; a master that offers one channel alone simply waits
    assign wr_go = CLK_EN_IN & S_AXI_AWVALID_IN & S_AXI_WVALID_IN & ~S_AXI_BVALID_OUT;
    assign S_AXI_AWREADY_OUT = wr_go;
    assign S_AXI_WREADY_OUT = wr_go;
    assign wa = S_AXI_AWADDR_IN;

    // write decode; status is read-only but still answers okay
    assign wr_ctrl = wr_go & (wa == `TPWM_OFF_CTRL);
    assign wr_cmpf = wr_go & (wa == `TPWM_OFF_CMPF);
    assign wr_cmps = wr_go & (wa == `TPWM_OFF_CMPS);
    assign wr_shdf = wr_go & (wa == `TPWM_OFF_SHDF);
    assign wr_shds = wr_go & (wa == `TPWM_OFF_SHDS);
    assign wr_mapped = wr_ctrl | wr_cmpf | wr_cmps | wr_shdf | wr_shds
                       | (wa == `TPWM_OFF_STAT);

    // merged write data per register
    assign wd_ctrl = merge({22'h000000, ctrl_r}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
    assign wd_cmpf = merge({15'h0000, compare_first_r}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
    assign wd_cmps = merge({15'h0000, compare_second_r}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
    assign wd_shdf = merge({15'h0000, shadow_first_r}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
    assign wd_shds = merge({15'h0000, shadow_second_r}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);

    // write response, held until the master takes it
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= `TPWM_RESP_OKAY;
        end else if (CLK_EN_IN) begin
            if (wr_go) begin
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT <= wr_mapped ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
            end else if (S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
            end
        end
    end

    // control and shadow registers
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_r <= `TPWM_CTRL_RST;
            shadow_first_r <= `TPWM_CMP_RST;
            shadow_second_r <= `TPWM_CMP_RST;
        end else if (CLK_EN_IN) begin
            if (wr_ctrl) begin
                ctrl_r <= wd_ctrl[`TPWM_CTRL_W-1:0];
            end
            if (wr_shdf) begin
                shadow_first_r <= wd_shdf[`TPWM_CMP_W-1:0];
            end
            if (wr_shds) begin
                shadow_second_r <= wd_shds[`TPWM_CMP_W-1:0];
            end
        end
    end

    // period end: own compare in free mode, trigger in triggered mode;
    // counter at max also wraps so first compare above max is legal
    // max itself is a real compare; above max only ends on the wrap
    assign cnt_ext = {1'b0, cnt_r};
    assign own_wrap = tick & ~trigger_reset_select
                      & ((cnt_ext == compare_first_r) | (cnt_r == `TPWM_CNT_MAX));
    // trigger acts on the cycle it emerges, not on the next tick, so a
    // delayed trigger with a slow divider still starts the period
    assign restart = chan_en & ((trigger_reset_select & trig_dly) | own_wrap);

    // next counter value
    // a disabled channel parks at zero, so enabling starts clean
    always @* begin
        if (!chan_en) begin
            cnt_nxt = `TPWM_CNT_RST;
        end else if (restart) begin
            cnt_nxt = `TPWM_CNT_RST;
        end else if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // compare values: direct write wins over a shadow load in the same
    // cycle, since software asked for that value last
    // shadows load only at restart so a running period keeps its values
    always @* begin
        compare_first_nxt = compare_first_r;
        compare_second_nxt = compare_second_r;
        if (restart && sync_update_en) begin
            compare_first_nxt = shadow_first_r;
            compare_second_nxt = shadow_second_r;
        end
        if (wr_cmpf) begin
            compare_first_nxt = wd_cmpf[`TPWM_CMP_W-1:0];
        end
        if (wr_cmps) begin
            compare_second_nxt = wd_cmps[`TPWM_CMP_W-1:0];
        end
    end

    // output level from the next count and next compares. being a level
    // rather than an event, no edge can be skipped by delay or divider
    always @* begin
        if (!chan_en) begin
            level_nxt = ~signal_level_bit;
        end else if (!trigger_reset_select) begin
            // free mode: first sets the period, second the duty
            if ({1'b0, cnt_nxt} < compare_second_nxt) begin
                level_nxt = signal_level_bit;
            end else begin
                level_nxt = ~signal_level_bit;
            end
        end else if (compare_first_nxt <= compare_second_nxt) begin
            // first edge to level, second back; first zero and
            // second above max keeps the level for the whole period
            if (({1'b0, cnt_nxt} >= compare_first_nxt)
                && ({1'b0, cnt_nxt} < compare_second_nxt)) begin
                level_nxt = signal_level_bit;
            end else begin
                level_nxt = ~signal_level_bit;
            end
        end else begin
            // second edge comes first: inverse level only between the two
            // edges, so swapped compares with the level inverted give the
            // same wave; second zero gives left aligned, with first above
            // max it gives 0% duty. second one still drops the level at
            // count one, whatever the divider or trigger delay
            if (({1'b0, cnt_nxt} >= compare_second_nxt)
                && ({1'b0, cnt_nxt} < compare_first_nxt)) begin
                level_nxt = ~signal_level_bit;
            end else begin
                level_nxt = signal_level_bit;
            end
        end
    end

    // channel registers
    // trigger out lags the restart by one cycle, like any registered stage
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cnt_r <= `TPWM_CNT_RST;
            compare_first_r <= `TPWM_CMP_RST;
            compare_second_r <= `TPWM_CMP_RST;
            PWM_OUT <= 1'b1;
            TRIG_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            cnt_r <= cnt_nxt;
            compare_first_r <= compare_first_nxt;
            compare_second_r <= compare_second_nxt;
            PWM_OUT <= level_nxt;
            TRIG_OUT <= restart; // period start for the next channel
        end
    end

    // read decode
    // status shows the live counter, so two reads of it seldom match
    always @* begin
        rd_data = 32'h00000000;
        rd_mapped = 1'b1;
        case (S_AXI_ARADDR_IN)
            `TPWM_OFF_CTRL: rd_data = {22'h000000, ctrl_r};
            `TPWM_OFF_CMPF: rd_data = {15'h0000, compare_first_r};
            `TPWM_OFF_CMPS: rd_data = {15'h0000, compare_second_r};
            `TPWM_OFF_SHDF: rd_data = {15'h0000, shadow_first_r};
            `TPWM_OFF_SHDS: rd_data = {15'h0000, shadow_second_r};
            `TPWM_OFF_STAT: begin
                rd_data[`TPWM_CNT_W-1:0] = cnt_r;
                rd_data[`TPWM_STAT_OUT] = PWM_OUT;
                rd_data[`TPWM_STAT_RUN] = chan_en;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    // read handshake: one read at a time, data held until taken
    assign rd_go = CLK_EN_IN & S_AXI_ARVALID_IN & ~S_AXI_RVALID_OUT;
    assign S_AXI_ARREADY_OUT = rd_go;

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h00000000;
            S_AXI_RRESP_OUT <= `TPWM_RESP_OKAY;
        end else if (CLK_EN_IN) begin
            if (rd_go) begin
                S_AXI_RVALID_OUT <= 1'b1;
                S_AXI_RDATA_OUT <= rd_data;
                S_AXI_RRESP_OUT <= rd_mapped ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
            end else if (S_AXI_RREADY_IN) begin
                S_AXI_RVALID_OUT <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ==== tpwm_defines.vh ====
/*
 * Register map, field positions, reset values and limits of the
 * triggered PWM channel.
 * Assumes: included by bare name from the channel's design files.
 */
`ifndef TPWM_DEFINES_VH
`define TPWM_DEFINES_VH

// byte addresses on the register bus
`define TPWM_OFF_CTRL 8'h00
`define TPWM_OFF_CMPF 8'h04
`define TPWM_OFF_CMPS 8'h08
`define TPWM_OFF_SHDF 8'h0C
`define TPWM_OFF_SHDS 8'h10
`define TPWM_OFF_STAT 8'h14

// control register fields
`define TPWM_CTRL_EN 0
`define TPWM_CTRL_TRS 1
`define TPWM_CTRL_SL 2
`define TPWM_CTRL_SYNC 3
`define TPWM_CTRL_DIV_LO 4
`define TPWM_CTRL_DIV_HI 6
`define TPWM_CTRL_STG_LO 8
`define TPWM_CTRL_STG_HI 9
`define TPWM_CTRL_W 10

// status register fields
`define TPWM_STAT_OUT 16
`define TPWM_STAT_RUN 17

// reset values
`define TPWM_CTRL_RST 10'h000
`define TPWM_CMP_RST 17'h00000
`define TPWM_CNT_RST 16'h0000

// counter and compare widths; compares carry one bit above the counter
`define TPWM_CNT_W 16
`define TPWM_CMP_W 17
`define TPWM_CNT_MAX 16'hFFFF

// bus answers
`define TPWM_RESP_OKAY 2'h0
`define TPWM_RESP_SLVERR 2'h2

`endif

// ==== tpwm_clkdiv.v ====
/*
 * Counting tick for the channel: the cluster clock divided by 2^sel.
 * Assumes: one clock, clock enable freezes the prescaler, restart_in
 * realigns the prescaler phase with a new period.
 */
`timescale 1ns/1ps
`default_nettype none

module tpwm_clkdiv (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // control
    input wire [2:0] sel_in,
    input wire restart_in,
    // tick
    output wire tick_out
);
    reg [6:0] pre_r;
    wire [6:0] mask;

    // mask of low bits that must be zero for a tick; sel 0 ticks always
    assign mask = ~(7'h7F << sel_in);
    assign tick_out = ce_in & ((pre_r & mask) == 7'h00);

    // restart loads phase one, so the restart cycle counts as the tick that starts a triggered period
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_r <= 7'h00;
        end else if (ce_in) begin
            if (restart_in) begin
                pre_r <= 7'h01;
            end else begin
                pre_r <= pre_r + 7'h01;
            end
        end
    end
endmodule

`default_nettype wire

// ==== tpwm_trigpipe.v ====
/*
 * Trigger path from the preceding channel: zero to three register
 * stages, chosen at run time, modelling pipeline or sync delay.
 * Assumes: trig_in is a one-cycle pulse synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module tpwm_trigpipe (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // control
    input wire [1:0] stages_in,
    // trigger
    input wire trig_in,
    output reg trig_out
);
    wire [3:0] tap;

    assign tap[0] = trig_in;

    // one flip-flop per stage
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_stage
            reg stage_r;
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    stage_r <= 1'b0;
                end else if (ce_in) begin
                    stage_r <= tap[i];
                end
            end
            assign tap[i+1] = stage_r;
        end
    endgenerate

    // tap selection
    always @* begin
        case (stages_in)
            2'h0: trig_out = tap[0];
            2'h1: trig_out = tap[1];
            2'h2: trig_out = tap[2];
            default: trig_out = tap[3];
        endcase
    end
endmodule

`default_nettype wire

// ==== tpwm_trig_src.sv ====
/* Preceding-channel model: a one-cycle trigger pulse every period_in cycles.
   Assumes the bench clock and the active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module tpwm_trig_src (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic [7:0] period_in,
    // trigger
    output logic trig_out
);
    logic [7:0] cnt_r;
    // free count; the pulse lasts one cycle whenever period_in is above one
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 8'h00;
            trig_out <= 1'b0;
        end else begin
            cnt_r <= (cnt_r >= period_in - 8'h01) ? 8'h00 : cnt_r + 8'h01;
            trig_out <= (cnt_r == 8'h00);
        end
    end
endmodule
`default_nettype wire

// ==== tpwm_channel_chk.sv ====
/* Bus and freeze checker for the channel, bound to its top ports.
   Assumes one clock domain and the active-high async reset. */
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defines.vh"
module tpwm_channel_chk (
    // clock, reset, enable
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    // write side
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WVALID_IN,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic [1:0] S_AXI_BRESP_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // read side
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic [1:0] S_AXI_RRESP_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // channel
    input wire logic TRIG_OUT,
    input wire logic PWM_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    logic wr_map;
    logic rd_map;
    // only word offsets up to the status word are mapped
    assign wr_map = (S_AXI_AWADDR_IN <= 8'h14) && (S_AXI_AWADDR_IN[1:0] == 2'h0);
    assign rd_map = (S_AXI_ARADDR_IN <= 8'h14) && (S_AXI_ARADDR_IN[1:0] == 2'h0);
    aw_take_a: assert property (S_AXI_AWREADY_OUT |-> CLK_EN_IN && S_AXI_AWVALID_IN
        && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT) else $error("write taken out of turn");
    wr_resp_a: assert property (S_AXI_AWREADY_OUT |=> S_AXI_BVALID_OUT && S_AXI_BRESP_OUT ==
        ($past(wr_map) ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR)) else $error("bad write answer");
    b_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
        S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write answer dropped");
    b_drop_a: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN && CLK_EN_IN |=>
        !S_AXI_BVALID_OUT) else $error("write answer lingers");
    ar_take_a: assert property (S_AXI_ARREADY_OUT |-> CLK_EN_IN && S_AXI_ARVALID_IN
        && !S_AXI_RVALID_OUT) else $error("read taken out of turn");
    rd_resp_a: assert property (S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT && S_AXI_RRESP_OUT ==
        ($past(rd_map) ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR)) else $error("bad read answer");
    rd_zero_a: assert property (S_AXI_ARREADY_OUT && !rd_map |=>
        S_AXI_RDATA_OUT == 32'h00000000) else $error("unmapped read not zero");
    r_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT &&
        $stable(S_AXI_RDATA_OUT) && $stable(S_AXI_RRESP_OUT)) else $error("read answer moved");
    w_pair_a: assert property (S_AXI_WREADY_OUT == S_AXI_AWREADY_OUT)
        else $error("write channels taken apart");
    freeze_a: assert property (!CLK_EN_IN |=> $stable(PWM_OUT) && $stable(TRIG_OUT))
        else $error("output moved while frozen");
    // main scenarios reached
    wr_cov: cover property (S_AXI_AWREADY_OUT && !wr_map);
    rd_cov: cover property (S_AXI_ARREADY_OUT && !rd_map);
    trig_cov: cover property ($rose(TRIG_OUT));
    frz_cov: cover property (!CLK_EN_IN ##1 CLK_EN_IN);
endmodule
bind tpwm_channel tpwm_channel_chk u_chk (.*);
`default_nettype wire

// ==== testbench.sv ====
/* Self-checking bench for the triggered pwm channel: bus tasks, period
   and duty measurement. Assumes the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defines.vh"
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] prd = 8'h30;
    logic awready, wready, bvalid, arready, rvalid, trig, trig_o, pwm;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rdv;
    logic [4:0] hs;
    logic [31:0] rng = 32'hB0BA7C52;
    logic [31:0] wv [3] = '{32'hFFFF, 32'h10000, 32'hFFFFFFFF};
    int mismatches = 0;
    int n_compared = 0;
    int n, f, s, n_keep;
    // 100 MHz core clock
    always #5 clk = ~clk;
    assign hs = {trig_o, rvalid, arready, bvalid, awready};
    tpwm_trig_src u_src (.clk_in(clk), .rst_in(rst), .period_in(prd), .trig_out(trig));
    tpwm_channel DUT (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(ce),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .TRIG_IN(trig),
        .TRIG_OUT(trig_o), .PWM_OUT(pwm));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // high cycles over one trigger period, counter steps every 2^dv cycles
    function automatic int ones(input int a, input int b, input logic l, input int dv);
        int m = 0;
        int c;
        for (int k = 0; k < 48; k++) begin
            c = k >> dv;
            // edge to l at count a, edge to ~l at count b, in either order
            m += (a <= b) ? ((c >= a && c < b) ? l : !l) : ((c >= b && c < a) ? !l : l);
        end
        return m;
    endfunction
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g, input int t = 0);
        n_compared++;
        if (g !== e && (((g > e ? g - e : e - g) <= t) !== 1'b1)) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    // bounded wait for a handshake or trigger bit, sampled at rising edges
    task automatic wait_hi(input int w);
        int t;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (hs[w] !== 1'b1 && t < 300);
        if (hs[w] !== 1'b1) begin
            mismatches++;
            $display("MISMATCH wait %0d expected 1 seen %b", w, hs[w]);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wait_hi(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        wait_hi(1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wait_hi(2);
        arvalid <= 1'b0;
        rready <= 1'b1;
        wait_hi(3);
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic setup(input int a, input int b, input logic l, input int dv, input int st,
        input logic tr);
        wr(`TPWM_OFF_CMPF, a);
        wr(`TPWM_OFF_CMPS, b);
        wr(`TPWM_OFF_CTRL, {22'h0, st[1:0], 1'b0, dv[2:0], 1'b0, l, tr, 1'b1});
    endtask
    task automatic meas(output int m);
        wait_hi(4);
        m = 0;
        repeat (48) begin
            m += (pwm === 1'b1);
            @(posedge clk);
        end
    endtask
    task automatic gap(output int g);
        wait_hi(4);
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (trig_o !== 1'b1 && g < 300);
    endtask
    // the prescaler realigns on every restart, so the count is exact
    task automatic duty(input int a, input int b, input logic l, input int dv, input int st);
        int e;
        setup(a, b, l, dv, st, 1'b1);
        meas(n);
        meas(n);
        e = ones(a, b, l, dv);
        chk("duty", e, n);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog sized well above the expected run of a few thousand cycles
    initial begin
        #500000;
        mismatches++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`TPWM_OFF_CTRL);
        chk("ctrl reset", 32'h0, rdv);
        rd(`TPWM_OFF_STAT);
        chk("stat reset", 32'h00010000, rdv);
        rd(8'h18);
        chk("unmapped rresp", 2, resp);
        wr(`TPWM_OFF_STAT, 32'h0);
        chk("stat write", 0, resp);
        wr(8'h1D, 32'h0);
        chk("unmapped bresp", 2, resp);
        foreach (wv[i]) begin
            wr(`TPWM_OFF_CMPS, wv[i]);
            rd(`TPWM_OFF_CMPS);
            chk("cmp store", wv[i] & 32'h1FFFF, rdv);
        end
        $display("test registers done");
        setup(20, 10, 1'b1, 0, 0, 1'b0);
        gap(n);
        gap(n);
        chk("free period", 21, n);
        setup(20, 10, 1'b1, 0, 0, 1'b1);
        gap(n);
        gap(n);
        chk("trig period", 48, n);
        $display("test trigger select done");
        duty(32'h10000, 0, 1'b1, 1, 2);
        duty(10, 0, 1'b1, 0, 1);
        duty(5, 1, 1'b1, 1, 2);
        duty(9, 0, 1'b0, 2, 3);
        duty(0, 32'hFFFF, 1'b1, 1, 1);
        duty(0, 32'h10000, 1'b1, 0, 1);
        wait_hi(4);
        repeat (4) @(posedge clk);
        wr(`TPWM_OFF_CMPF, 40);
        @(posedge clk);
        chk("edge in period", 0, pwm);
        wr(`TPWM_OFF_CMPS, 0);
        meas(n);
        meas(n);
        chk("after leaving full", ones(40, 0, 1'b1, 0), n);
        $display("test direct update done");
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        wr(`TPWM_OFF_SHDF, 40);
        wr(`TPWM_OFF_SHDS, 0);
        wr(`TPWM_OFF_CTRL, 32'h0000010F);
        wait_hi(4);
        wr(`TPWM_OFF_SHDF, 0);
        wr(`TPWM_OFF_SHDS, 32'h10000);
        rd(`TPWM_OFF_CMPF);
        chk("no early load", 40, rdv);
        chk("level held", 0, pwm);
        wait_hi(4);
        chk("load at restart", 1, pwm);
        rd(`TPWM_OFF_CMPS);
        chk("shadow moved", 32'h10000, rdv);
        wr(`TPWM_OFF_CTRL, 32'h0);
        $display("test shadow update done");
        repeat (8) begin
            rng = lfsr(rng);
            f = (rng[6:4] == 3'h0) ? 32'h10000 : rng[3:0];
            s = (rng[14:12] == 3'h0) ? 32'h10000 : rng[11:8];
            duty(f, s, rng[16], rng[18:17] % 3, rng[20:19]);
            n_keep = n;
            if (f != s) begin
                duty(s, f, !rng[16], rng[18:17] % 3, rng[20:19]);
                chk("swapped", n_keep, n);
            end
        end
        $display("test random settings done");
        close_out();
    end
endmodule
`default_nettype wire
